// ---- rtl/seec_pkg.sv ----
// constants and carrier types for the state effecter enable command block
package seec_pkg;

  // effecter geometry
  localparam int unsigned NUM_SUB   = 8;
  localparam logic [3:0]  CNT_MIN   = 4'h1;
  localparam logic [3:0]  CNT_MAX   = 4'h8;

  // reserved handle values and the handle loaded at reset
  localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
  localparam logic [15:0] HANDLE_RSVD_HI = 16'hffff;
  localparam logic [15:0] HANDLE_RST     = 16'h0001;

  // operational setting codes
  localparam logic [7:0] OP_ENABLED     = 8'h00;
  localparam logic [7:0] OP_DISABLED    = 8'h02;
  localparam logic [7:0] OP_UNAVAILABLE = 8'h03;

  // event enable codes
  localparam logic [7:0] EV_ENABLE    = 8'h00;
  localparam logic [7:0] EV_DISABLE   = 8'h01;
  localparam logic [7:0] EV_NO_CHANGE = 8'hff;

  // completion codes
  localparam logic [7:0] CC_SUCCESS        = 8'h00;
  localparam logic [7:0] CC_INVALID_DATA   = 8'h02;
  localparam logic [7:0] CC_INVALID_LENGTH = 8'h03;
  localparam logic [7:0] CC_INVALID_ID     = 8'h80;

  // register byte addresses
  localparam logic [7:0] ADDR_HANDLE   = 8'h00;
  localparam logic [7:0] ADDR_DEFAULT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_VALUE_LO = 8'h14;
  localparam logic [7:0] ADDR_VALUE_HI = 8'h18;

  // field positions
  localparam int unsigned DFLT_MASK_LSB = 0;
  localparam int unsigned DFLT_VAL_LSB  = 8;
  localparam int unsigned STAT_EV_LSB   = 16;

  // interrupt bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_ERROR    = 1;
  localparam int unsigned IRQ_REFUSED  = 2;

  typedef enum logic [2:0] {
    SEEC_HLO,
    SEEC_HHI,
    SEEC_CNT,
    SEEC_OP,
    SEEC_EV,
    SEEC_DRAIN
  } seec_phase_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } seec_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } seec_resp_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] offset;
    logic [7:0] value;
  } seec_set_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } seec_bus_t;

endpackage

// ---- rtl/seec_top.sv ----
// state effecter enable command interpreter with register port and interrupt
// How it works
// - disabled effecter refuses any state change
// - optional return to default on disable
// - entries map to offsets zero upward
// - entry count must equal composite count
// - op field: enabled, disabled=2, unavailable
// - event field enables (0x00) or disables (0x01) events, 0xff keeps
// - completion code, 0x80 for bad handle
// - unavailable effecter treated as not applicable
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module seec_top (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire seec_pkg::seec_byte_t rx,
  output var  seec_pkg::seec_resp_t resp,
  input  wire seec_pkg::seec_set_t  set_req,
  input  wire seec_pkg::seec_bus_t  bus,
  output var  logic [31:0]          rdata,
  output var  logic [63:0]          state_value,
  output var  logic [7:0]           active,
  output var  logic [7:0]           events_on,
  output var  logic                 irq
);

  typedef struct packed {
    seec_pkg::seec_phase_t phase;
    logic [15:0]           handle;
    logic [3:0]            count;
    logic [3:0]            idx;
    logic [7:0]            err;
    logic [7:0][1:0]       pend_op;
    logic [7:0][1:0]       pend_ev;
    logic [7:0][1:0]       op;
    logic [7:0]            ev;
    logic [7:0]            act;
    logic [7:0][7:0]       val;
    logic [15:0]           own_handle;
    logic [7:0]            dflt_mask;
    logic [7:0]            dflt_val;
    logic [2:0]            irq_stat;
    logic [2:0]            irq_mask;
    logic                  irq;
    logic [31:0]           rdata;
    seec_pkg::seec_resp_t  resp;
  } seec_state_t;

  seec_state_t s_reg;
  seec_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic [2:0]  ev_set;
  logic [15:0] stat_op;
  logic [7:0]  b;
  logic        commit;
  logic        op_ok;
  logic        ev_ok;

  always_comb begin
    s_next = s_reg;
    ev_set = '0;
    commit = 1'b0;
    b      = rx.data;
    s_next.resp.valid = 1'b0;
    op_ok  = (b == seec_pkg::OP_ENABLED) || (b == seec_pkg::OP_DISABLED) ||
             (b == seec_pkg::OP_UNAVAILABLE);
    ev_ok  = (b == seec_pkg::EV_ENABLE) || (b == seec_pkg::EV_DISABLE) ||
             (b == seec_pkg::EV_NO_CHANGE);

    // request parsing, one byte per valid cycle
    if (rx.valid) begin
      case (s_reg.phase)
        seec_pkg::SEEC_HLO: begin
          s_next.handle[7:0] = b;
          s_next.err         = seec_pkg::CC_SUCCESS;
          s_next.idx         = '0;
          s_next.phase       = seec_pkg::SEEC_HHI;
        end
        seec_pkg::SEEC_HHI: begin
          s_next.handle[15:8] = b;
          if ({b, s_reg.handle[7:0]} == seec_pkg::HANDLE_RSVD_LO ||
              {b, s_reg.handle[7:0]} == seec_pkg::HANDLE_RSVD_HI ||
              {b, s_reg.handle[7:0]} != s_reg.own_handle) begin
            s_next.err = seec_pkg::CC_INVALID_ID;
          end
          s_next.phase = seec_pkg::SEEC_CNT;
        end
        seec_pkg::SEEC_CNT: begin
          s_next.count = b[3:0];
          if ((b[7:4] != 4'h0 || b[3:0] < seec_pkg::CNT_MIN || b[3:0] > seec_pkg::CNT_MAX) &&
              s_reg.err == seec_pkg::CC_SUCCESS) begin
            s_next.err = seec_pkg::CC_INVALID_DATA;
          end
          s_next.phase = seec_pkg::SEEC_OP;
        end
        seec_pkg::SEEC_OP: begin
          if (!op_ok && s_reg.err == seec_pkg::CC_SUCCESS) begin
            s_next.err = seec_pkg::CC_INVALID_DATA;
          end
          s_next.pend_op[s_reg.idx[2:0]] = b[1:0];
          s_next.phase = seec_pkg::SEEC_EV;
        end
        seec_pkg::SEEC_EV: begin
          if (!ev_ok && s_reg.err == seec_pkg::CC_SUCCESS) begin
            s_next.err = seec_pkg::CC_INVALID_DATA;
          end
          s_next.pend_ev[s_reg.idx[2:0]] = (b == seec_pkg::EV_NO_CHANGE) ? 2'b10 : {1'b0, b[0]};
          s_next.idx   = s_reg.idx + 4'h1;
          s_next.phase = (s_reg.idx + 4'h1 >= s_reg.count) ? seec_pkg::SEEC_DRAIN : seec_pkg::SEEC_OP;
        end
        seec_pkg::SEEC_DRAIN: begin
          // surplus bytes past the last entry
          if (s_reg.err == seec_pkg::CC_SUCCESS) begin
            s_next.err = seec_pkg::CC_INVALID_LENGTH;
          end
        end
        default: begin
          s_next.phase = seec_pkg::SEEC_HLO;
        end
      endcase

      if (rx.last) begin
        s_next.phase      = seec_pkg::SEEC_HLO;
        s_next.resp.valid = 1'b1;
        // message must end on the final entry
        if (s_next.err == seec_pkg::CC_SUCCESS &&
            !(s_reg.phase == seec_pkg::SEEC_EV && s_reg.idx + 4'h1 == s_reg.count)) begin
          s_next.err = seec_pkg::CC_INVALID_LENGTH;
        end
        s_next.resp.code = s_next.err;
        commit = (s_next.err == seec_pkg::CC_SUCCESS);
        ev_set[seec_pkg::IRQ_DONE]  = 1'b1;
        ev_set[seec_pkg::IRQ_ERROR] = !commit;
      end
    end

    if (set_req.valid) begin
      if (s_reg.op[set_req.offset] == seec_pkg::OP_ENABLED[1:0]) begin
        s_next.val[set_req.offset] = set_req.value;
      end else begin
        ev_set[seec_pkg::IRQ_REFUSED] = 1'b1;
      end
    end

    // a completed request commits all entries at once
    if (commit) begin
      for (int i = 0; i < seec_pkg::NUM_SUB; i++) begin
        if (i < int'(s_reg.count)) begin
          s_next.op[i] = s_next.pend_op[i];
          if (s_next.pend_op[i] == seec_pkg::OP_DISABLED[1:0] &&
              s_reg.op[i] != seec_pkg::OP_DISABLED[1:0] && s_reg.dflt_mask[i]) begin
            s_next.val[i] = s_reg.dflt_val;
          end
          // apply event enable unless no change
          if (!s_next.pend_ev[i][1]) begin
            s_next.ev[i] = (s_next.pend_ev[i][0] == seec_pkg::EV_ENABLE[0]);
          end
        end
      end
    end

    // active flags registered so the output comes from a flip-flop like the rest
    for (int i = 0; i < seec_pkg::NUM_SUB; i++) begin
      stat_op[2*i +: 2] = s_reg.op[i];
      s_next.act[i]     = (s_next.op[i] == seec_pkg::OP_ENABLED[1:0]);
    end

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        seec_pkg::ADDR_HANDLE:   s_next.own_handle = bus.wdata[15:0];
        seec_pkg::ADDR_DEFAULT: begin
          s_next.dflt_mask = bus.wdata[seec_pkg::DFLT_MASK_LSB +: 8];
          s_next.dflt_val  = bus.wdata[seec_pkg::DFLT_VAL_LSB +: 8];
        end
        seec_pkg::ADDR_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~bus.wdata[2:0];
        seec_pkg::ADDR_IRQ_MASK: s_next.irq_mask = bus.wdata[2:0];
        default: begin
        end
      endcase
    end
    // new events win over a same-cycle clear
    s_next.irq_stat = s_next.irq_stat | ev_set;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    // register reads, data in the following cycle; unmapped reads zero
    s_next.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        seec_pkg::ADDR_HANDLE:   s_next.rdata = {16'h0000, s_reg.own_handle};
        seec_pkg::ADDR_DEFAULT:  s_next.rdata = {16'h0000, s_reg.dflt_val, s_reg.dflt_mask};
        seec_pkg::ADDR_STATUS:   s_next.rdata = {8'h00, s_reg.ev, stat_op};
        seec_pkg::ADDR_IRQ_STAT: s_next.rdata = {29'h0, s_reg.irq_stat};
        seec_pkg::ADDR_IRQ_MASK: s_next.rdata = {29'h0, s_reg.irq_mask};
        seec_pkg::ADDR_VALUE_LO: s_next.rdata = s_reg.val[3:0];
        seec_pkg::ADDR_VALUE_HI: s_next.rdata = s_reg.val[7:4];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg            <= '0;
      s_reg.own_handle <= seec_pkg::HANDLE_RST;
      s_reg.ev         <= 8'hff;
      s_reg.act        <= 8'hff;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign resp        = s_reg.resp;
  assign rdata       = s_reg.rdata;
  assign state_value = s_reg.val;
  assign irq         = s_reg.irq;
  assign events_on   = s_reg.ev;
  assign active      = s_reg.act;

endmodule
`default_nettype wire

// ---- tb/seec_properties.sv ----
// concurrent checks on the enable command block ports
`timescale 1ns/1ps
`default_nettype none
module seec_properties (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire seec_pkg::seec_byte_t rx,
  input wire seec_pkg::seec_resp_t resp,
  input wire seec_pkg::seec_set_t  set_req,
  input wire seec_pkg::seec_bus_t  bus,
  input wire logic [31:0]          rdata,
  input wire logic [63:0]          state_value,
  input wire logic [7:0]           active,
  input wire logic [7:0]           events_on,
  input wire logic                 irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence msg_end;
    rx.valid && rx.last;
  endsequence
  // a commit in the same cycle may legally override the set
  sequence set_open;
    set_req.valid && active[set_req.offset] && !(rx.valid && rx.last);
  endsequence
  sequence set_shut;
    set_req.valid && !active[set_req.offset] && !(rx.valid && rx.last);
  endsequence
  ////////////////////////////////////////
  resp_follows_a:
    assert property (msg_end |=> resp.valid) else $error("no response after last byte");
  resp_cause_a:
    assert property (resp.valid |-> $past(rx.valid && rx.last)) else $error("response without message end");
  code_holds_a:
    assert property (!resp.valid |-> $stable(resp.code)) else $error("code moved without response");
  refused_set_a:
    assert property (set_shut |=> $stable(state_value)) else $error("disabled effecter changed");
  set_lands_a:
    assert property (set_open |=> state_value[8*$past(set_req.offset) +: 8] == $past(set_req.value))
      else $error("enabled effecter not updated");
  active_hold_a:
    assert property (!(rx.valid && rx.last) |=> $stable(active)) else $error("op state moved without commit");
  events_hold_a:
    assert property (!(rx.valid && rx.last) |=> $stable(events_on)) else $error("event enables moved without commit");
  rdata_idle_a:
    assert property (!bus.rd |=> rdata == 32'h0) else $error("read data outside read slot");
  irq_clear_a:
    assert property ($fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2)) else $error("irq fell without write");
endmodule
bind seec_top seec_properties u_props (.clock(clock), .rst(rst), .rx(rx), .resp(resp), .set_req(set_req),
  .bus(bus), .rdata(rdata), .state_value(state_value), .active(active), .events_on(events_on), .irq(irq));
`default_nettype wire

// ---- tb/seec_requester.sv ----
// management requester model: streams request bytes and collects the code
`timescale 1ns/1ps
`default_nettype none
module seec_requester (
  input  wire logic                 clock,
  input  wire seec_pkg::seec_resp_t resp,
  output var  seec_pkg::seec_byte_t rx
);
  logic [7:0] code;
  initial rx = '0;
  // bytes go out whole, in the order the caller composed
  task automatic send(input logic [7:0] msg [$]);
    foreach (msg[i]) begin
      @(posedge clock);
      rx <= '{valid: 1'b1, last: (i == msg.size() - 1), data: msg[i]};
    end
    @(posedge clock);
    // idle data inverted so a stale byte never looks fresh
    rx <= '{valid: 1'b0, last: 1'b0, data: ~msg[msg.size() - 1]};
    #1 code = resp.valid ? resp.code : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the enable command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clock;
  logic                 rst;
  seec_pkg::seec_byte_t rx;
  seec_pkg::seec_resp_t resp;
  seec_pkg::seec_set_t  set_req;
  seec_pkg::seec_bus_t  bus;
  logic [31:0]          rdata;
  logic [63:0]          state_value;
  logic [7:0]           active;
  logic [7:0]           events_on;
  logic                 irq;
  int                   err_total;
  int                   comparisons;
  logic [7:0]           msg [$];
  seec_top dut (.clock(clock), .rst(rst), .rx(rx), .resp(resp), .set_req(set_req), .bus(bus), .rdata(rdata),
    .state_value(state_value), .active(active), .events_on(events_on), .irq(irq));
  seec_requester u_req (.clock(clock), .resp(resp), .rx(rx));
  ////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h0, got}, {24'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk32(rdata, exp);
  endtask
  task automatic put(input logic [2:0] o, input logic [7:0] v);
    @(posedge clock);
    set_req <= '{valid: 1'b1, offset: o, value: v};
    @(posedge clock);
    set_req.valid <= 1'b0;
    #1;
  endtask
  task automatic req(input logic [7:0] m [$], input logic [7:0] cc);
    u_req.send(m);
    chk8(u_req.code, cc);
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    set_req = '0;
    bus = '0;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1 chk8(active, 8'hff);
    chk8(events_on, 8'hff);
    wr(seec_pkg::ADDR_DEFAULT, 32'h0000_a502);
    wr(seec_pkg::ADDR_IRQ_MASK, 32'h7);
    put(3'h3, 8'h55);
    chk8(state_value[31:24], 8'h55);
    req({8'h01, 8'h00, 8'h02, 8'h02, 8'h01, 8'h02, 8'hff}, seec_pkg::CC_SUCCESS);
    chk8(active, 8'hfc);
    chk8(events_on, 8'hfe);
    chk8(state_value[15:8], 8'ha5);
    rd(seec_pkg::ADDR_STATUS, 32'h00fe_000a);
    put(3'h0, 8'h77);
    chk8(state_value[7:0], 8'h00);
    rd(seec_pkg::ADDR_IRQ_STAT, 32'h5);
    chk8({7'h0, irq}, 8'h01);
    rd(seec_pkg::ADDR_VALUE_LO, 32'h5500_a500);
    wr(seec_pkg::ADDR_IRQ_STAT, 32'h7);
    wr(seec_pkg::ADDR_IRQ_MASK, 32'h4);
    rd(8'hfc, 32'h0);
    req({8'hff, 8'hff, 8'h01, 8'h00, 8'h00}, seec_pkg::CC_INVALID_ID);
    req({8'h00, 8'h00, 8'h01, 8'h00, 8'h00}, seec_pkg::CC_INVALID_ID);
    rd(seec_pkg::ADDR_IRQ_STAT, 32'h3);
    chk8({7'h0, irq}, 8'h00);
    wr(seec_pkg::ADDR_IRQ_STAT, 32'h2);
    wr(seec_pkg::ADDR_HANDLE, 32'h1234);
    rd(seec_pkg::ADDR_HANDLE, 32'h0000_1234);
    rd(seec_pkg::ADDR_DEFAULT, 32'h0000_a502);
    req({8'h12, 8'h34, 8'h01, 8'h00, 8'h00}, seec_pkg::CC_INVALID_ID);
    req({8'h34, 8'h12, 8'h00}, seec_pkg::CC_INVALID_DATA);
    req({8'h34, 8'h12, 8'h02, 8'h00, 8'h00}, seec_pkg::CC_INVALID_LENGTH);
    req({8'h34, 8'h12, 8'h01, 8'h01, 8'h00}, seec_pkg::CC_INVALID_DATA);
    req({8'h34, 8'h12, 8'h01, 8'h00, 8'h02}, seec_pkg::CC_INVALID_DATA);
    chk8(active, 8'hfc);
    msg = {8'h34, 8'h12, 8'h08};
    for (int i = 0; i < 8; i++) begin
      msg.push_back(i[0] ? seec_pkg::OP_UNAVAILABLE : seec_pkg::OP_ENABLED);
      msg.push_back(i[1] ? seec_pkg::EV_DISABLE : seec_pkg::EV_NO_CHANGE);
    end
    req(msg, seec_pkg::CC_SUCCESS);
    chk8(active, 8'h55);
    chk8(events_on, 8'h32);
    req({8'h34, 8'h12, 8'h01, 8'h00, 8'h00}, seec_pkg::CC_SUCCESS);
    chk8(events_on, 8'h33);
    chk8(active, 8'h55);
    put(3'h1, 8'h66);
    chk8(state_value[15:8], 8'ha5);
    put(3'h0, 8'h77);
    chk8(state_value[7:0], 8'h77);
    rd(seec_pkg::ADDR_VALUE_LO, 32'h5500_a577);
    rd(seec_pkg::ADDR_VALUE_HI, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
